// ### verilog/mdae_pkg.sv
// Alarm encoder constants, types and descriptor lookup
// How it works
// - Overvoltage: code 22, 3 blinks, hard latch
// - Start without main power: code 23, soft
// - Main power dip or low: code 25
// - Current-on deviation overflow: code 10, 4 blinks
// - Current on during overflow warning: code 12
// - Output short: code 20, 5 blinks, hard
// - Motor cable open: code 2D, hard
// - Gear resolution out of range: code 71
// - Sensor fault while running: code 28
// - Sensor fault at power-up: code 42
// - Shaft turning at init: code 43
// - Unsupported motor type: code 45
// - Stored data corrupt: code 41, 9 blinks
// - De-energising alarm cuts current, brake holds
// - Energised-class alarm keeps motor current on
// - Clear input or tool clears soft alarms
// - Codes 23, 20, 2D only on AC variant
// - Hard alarms clear only by power cycle
package mdae_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned BLINK_TICK_NS = 200_000_000;
    localparam int unsigned TICK_CYC_DFLT = BLINK_TICK_NS / CLK_PERIOD_NS;
    localparam logic [3:0]  PAUSE_TICKS   = 4'h4;

    localparam logic [15:0] GEAR_MIN      = 16'h0064;
    localparam logic [15:0] GEAR_MAX      = 16'h2710;
    localparam logic [15:0] ROTOR_RPM_MAX = 16'h000F;

    localparam logic [7:0] CODE_OVERVOLT = 8'h22;
    localparam logic [7:0] CODE_MAINOFF  = 8'h23;
    localparam logic [7:0] CODE_UNDERV   = 8'h25;
    localparam logic [7:0] CODE_DEV_ON   = 8'h10;
    localparam logic [7:0] CODE_DEV_OFF  = 8'h12;
    localparam logic [7:0] CODE_SHORT    = 8'h20;
    localparam logic [7:0] CODE_CABLE    = 8'h2D;
    localparam logic [7:0] CODE_OPDATA   = 8'h70;
    localparam logic [7:0] CODE_GEAR     = 8'h71;
    localparam logic [7:0] CODE_SNS_RUN  = 8'h28;
    localparam logic [7:0] CODE_SNS_INIT = 8'h42;
    localparam logic [7:0] CODE_ROTOR    = 8'h43;
    localparam logic [7:0] CODE_MTYPE    = 8'h45;
    localparam logic [7:0] CODE_STORE    = 8'h41;

    localparam logic [2:0] GRP_3 = 3'h3;
    localparam logic [2:0] GRP_4 = 3'h4;
    localparam logic [2:0] GRP_5 = 3'h5;
    localparam logic [2:0] GRP_7 = 3'h7;
    localparam logic [2:0] GRP_8 = 3'h0;
    localparam logic [2:0] GRP_9 = 3'h1;

    typedef enum {
        ALM_NONE, ALM_OVERVOLT, ALM_MAINOFF, ALM_UNDERV, ALM_DEV_ON,
        ALM_DEV_OFF, ALM_SHORT, ALM_CABLE, ALM_OPDATA, ALM_GEAR,
        ALM_SNS_RUN, ALM_SNS_INIT, ALM_ROTOR, ALM_MTYPE, ALM_STORE
    } mdae_alarm_t;

    typedef struct packed {
        logic supply_over;
        logic main_power_ok;
        logic logic_supply_ok;
        logic motion_start;
        logic main_undervolt;
        logic deviation_over;
        logic off_overflow_warn;
        logic short_det;
        logic cable_open;
        logic sensor_fault;
        logic motor_running;
        logic init_busy;
        logic motor_type_bad;
        logic store_corrupt;
        logic home_start;
        logic op_data_warn;
    } mdae_sense_t;

    typedef struct packed {
        logic       active;
        logic [7:0] code;
        logic [2:0] grp;
        logic [3:0] blinks;
        logic       resettable;
        logic       excite;
    } mdae_desc_t;

    function automatic mdae_desc_t mdae_desc(input mdae_alarm_t a);
        mdae_desc_t d;
        d = '0;
        d.active = 1'b1;
        case (a)
            ALM_OVERVOLT: d = '{1'b1, CODE_OVERVOLT, GRP_3, 4'h3, 1'b0, 1'b0};
            ALM_MAINOFF:  d = '{1'b1, CODE_MAINOFF, GRP_3, 4'h3, 1'b1, 1'b0};
            ALM_UNDERV:   d = '{1'b1, CODE_UNDERV, GRP_3, 4'h3, 1'b1, 1'b0};
            ALM_DEV_ON:   d = '{1'b1, CODE_DEV_ON, GRP_4, 4'h4, 1'b1, 1'b0};
            ALM_DEV_OFF:  d = '{1'b1, CODE_DEV_OFF, GRP_4, 4'h4, 1'b1, 1'b0};
            ALM_SHORT:    d = '{1'b1, CODE_SHORT, GRP_5, 4'h5, 1'b0, 1'b0};
            ALM_CABLE:    d = '{1'b1, CODE_CABLE, GRP_5, 4'h5, 1'b0, 1'b0};
            ALM_OPDATA:   d = '{1'b1, CODE_OPDATA, GRP_7, 4'h7, 1'b1, 1'b1};
            ALM_GEAR:     d = '{1'b1, CODE_GEAR, GRP_7, 4'h7, 1'b0, 1'b0};
            ALM_SNS_RUN:  d = '{1'b1, CODE_SNS_RUN, GRP_8, 4'h8, 1'b0, 1'b0};
            ALM_SNS_INIT: d = '{1'b1, CODE_SNS_INIT, GRP_8, 4'h8, 1'b0, 1'b0};
            ALM_ROTOR:    d = '{1'b1, CODE_ROTOR, GRP_8, 4'h8, 1'b0, 1'b0};
            ALM_MTYPE:    d = '{1'b1, CODE_MTYPE, GRP_8, 4'h8, 1'b0, 1'b0};
            ALM_STORE:    d = '{1'b1, CODE_STORE, GRP_9, 4'h9, 1'b0, 1'b0};
            default:      d = '0;
        endcase
        return d;
    endfunction : mdae_desc

endpackage : mdae_pkg

// ### verilog/mdae_blink.sv
// Alarm LED sequencer: N blinks then a pause, repeated
`timescale 1ns/1ps
module mdae_blink
    import mdae_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       tick,
    input  wire logic [3:0] count,
    output logic            led_r
);
    typedef enum {BL_IDLE, BL_ON, BL_OFF, BL_PAUSE} mdae_bl_t;

    mdae_bl_t   st_r;
    logic [3:0] cnt_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_r  <= BL_IDLE;
            cnt_r <= 4'h0;
            led_r <= 1'b0;
        end else if (count == 4'h0) begin
            st_r  <= BL_IDLE;
            cnt_r <= 4'h0;
            led_r <= 1'b0;
        end else if (tick) begin
            case (st_r)
                BL_IDLE, BL_PAUSE: begin
                    if (st_r == BL_IDLE || cnt_r == PAUSE_TICKS) begin
                        st_r  <= BL_ON;
                        cnt_r <= 4'h1;
                        led_r <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r + 4'h1;
                    end
                end
                BL_ON: begin
                    st_r  <= BL_OFF;
                    led_r <= 1'b0;
                end
                BL_OFF: begin
                    if (cnt_r >= count) begin
                        st_r  <= BL_PAUSE;
                        cnt_r <= 4'h1;
                    end else begin
                        st_r  <= BL_ON;
                        cnt_r <= cnt_r + 4'h1;
                        led_r <= 1'b1;
                    end
                end
                default: begin
                    st_r  <= BL_IDLE;
                    led_r <= 1'b0;
                end
            endcase
        end
    end
endmodule : mdae_blink

// ### verilog/mdae_top.sv
// Alarm detection, latching and coded reporting for the motor driver
`timescale 1ns/1ps
module mdae_top
    import mdae_pkg::*;
#(
    parameter logic        AC_VARIANT = 1'b1,
    parameter int unsigned TICK_CYC   = TICK_CYC_DFLT
)
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire mdae_sense_t sense,
    input  wire logic [15:0] gear_resolution,
    input  wire logic [15:0] shaft_speed_rpm,
    input  wire logic        alarm_clear_input,
    input  wire logic        tool_reset,
    input  wire logic        current_on,
    input  wire logic        brake_fitted,
    output logic             alarm_active,
    output logic [7:0]       alarm_code,
    output logic             alarm_group_bit2,
    output logic             alarm_group_bit1,
    output logic             alarm_group_bit0,
    output logic [3:0]       blink_count,
    output logic             motor_energise,
    output logic             brake_release,
    output logic             alarm_led
);

    mdae_alarm_t alm_r;
    mdae_alarm_t alm_nxt;
    mdae_alarm_t cand;
    mdae_desc_t  desc_r;
    mdae_desc_t  desc_nxt;
    logic        pwrup_r;
    logic        clr_d_r;
    logic        con_d_r;
    logic        clr_req;
    logic        con_rise;
    logic        gear_bad;
    logic        energise_r;
    logic        brake_rel_r;
    logic [31:0] tick_cnt_r;
    logic        tick_r;

    // Edge and power-up tracking
    always_ff @(posedge clk) begin
        if (!resetn) begin
            clr_d_r <= 1'b0;
            con_d_r <= 1'b0;
            pwrup_r <= 1'b1;
        end else begin
            clr_d_r <= alarm_clear_input;
            con_d_r <= current_on;
            pwrup_r <= 1'b0;
        end
    end

    assign clr_req  = (alarm_clear_input & ~clr_d_r) | tool_reset;
    assign con_rise = current_on & ~con_d_r;
    assign gear_bad = (gear_resolution < GEAR_MIN) ||
                      (gear_resolution > GEAR_MAX);

    // Fault priority, most severe first
    always_comb begin
        cand = ALM_NONE;
        if (sense.supply_over)
            cand = ALM_OVERVOLT;
        else if (AC_VARIANT && sense.short_det)
            cand = ALM_SHORT;
        else if (AC_VARIANT && sense.cable_open)
            cand = ALM_CABLE;
        else if (sense.store_corrupt)
            cand = ALM_STORE;
        else if (sense.motor_type_bad)
            cand = ALM_MTYPE;
        else if (sense.sensor_fault && sense.init_busy)
            cand = ALM_SNS_INIT;
        else if (sense.init_busy && shaft_speed_rpm >= ROTOR_RPM_MAX)
            cand = ALM_ROTOR;
        else if (sense.sensor_fault && sense.motor_running)
            cand = ALM_SNS_RUN;
        else if (pwrup_r && gear_bad)
            cand = ALM_GEAR;
        else if (sense.main_undervolt)
            cand = ALM_UNDERV;
        else if (AC_VARIANT && sense.motion_start &&
                 !sense.main_power_ok && sense.logic_supply_ok)
            cand = ALM_MAINOFF;
        else if (con_rise && sense.off_overflow_warn)
            cand = ALM_DEV_OFF;
        else if (current_on && sense.deviation_over)
            cand = ALM_DEV_ON;
        else if (sense.home_start && sense.op_data_warn)
            cand = ALM_OPDATA;
    end

    always_comb begin
        alm_nxt = alm_r;
        if (alm_r == ALM_NONE)
            alm_nxt = cand;
        // only soft alarms clear, new event wins
        else if (clr_req && desc_r.resettable)
            alm_nxt = cand;
    end

    assign desc_nxt = mdae_desc(alm_nxt);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            alm_r  <= ALM_NONE;
            desc_r <= '0;
        end else begin
            alm_r  <= alm_nxt;
            desc_r <= desc_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            energise_r  <= 1'b0;
            brake_rel_r <= 1'b0;
        end else begin
            energise_r  <= current_on &
                           (~desc_nxt.active | desc_nxt.excite);
            brake_rel_r <= brake_fitted & current_on &
                           (~desc_nxt.active | desc_nxt.excite);
        end
    end

    // Blink rate divider
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tick_cnt_r <= 32'h0;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r >= 32'(TICK_CYC - 1)) begin
            tick_cnt_r <= 32'h0;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
            tick_r     <= 1'b0;
        end
    end

    mdae_blink u_blink (
        .clk    (clk),
        .resetn (resetn),
        .tick   (tick_r),
        .count  (desc_r.blinks),
        .led_r  (alarm_led)
    );

    assign alarm_active     = desc_r.active;
    assign alarm_code       = desc_r.code;
    assign alarm_group_bit2 = desc_r.grp[2];
    assign alarm_group_bit1 = desc_r.grp[1];
    assign alarm_group_bit0 = desc_r.grp[0];
    assign blink_count      = desc_r.blinks;
    assign motor_energise   = energise_r;
    assign brake_release    = brake_rel_r;

    // Coded group lines as one field
    logic [2:0] grp_lines;
    assign grp_lines = {alarm_group_bit2, alarm_group_bit1, alarm_group_bit0};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence held_s;
        alarm_active && !clr_req;
    endsequence

    sequence soft_clear_s;
        alarm_active && desc_r.resettable && clr_req && cand == ALM_NONE;
    endsequence

    ovv_report_a: assert property (sense.supply_over && !alarm_active |=>
        alarm_code == CODE_OVERVOLT && blink_count == 4'h3 &&
        !motor_energise)
        else $error("overvoltage alarm not reported");

    hard_hold_a: assert property (alarm_active && !desc_r.resettable
        && clr_req |=> alarm_active && $stable(alarm_code))
        else $error("hard alarm cleared by request");

    soft_clear_a: assert property (soft_clear_s |=> !alarm_active)
        else $error("soft alarm not cleared");

    held_stable_a: assert property (held_s |=>
        alarm_active && $stable(alarm_code) && $stable(blink_count))
        else $error("held alarm changed");

    dev_group_a: assert property (alarm_code == CODE_DEV_ON |->
        {alarm_group_bit2, alarm_group_bit1, alarm_group_bit0} == 3'h4
        && blink_count == 4'h4)
        else $error("deviation alarm coding wrong");

    short_group_a: assert property (alarm_code == CODE_SHORT |->
        {alarm_group_bit2, alarm_group_bit1, alarm_group_bit0} == 3'h5
        && blink_count == 4'h5 && !desc_r.resettable)
        else $error("short alarm coding wrong");

    store_group_a: assert property (alarm_code == CODE_STORE |->
        {alarm_group_bit2, alarm_group_bit1, alarm_group_bit0} == 3'h1
        && blink_count == 4'h9)
        else $error("store alarm coding wrong");

    cut_current_a: assert property (alarm_active &&
        alarm_code != CODE_OPDATA |-> !motor_energise && !brake_release)
        else $error("motor energised during alarm");

    keep_current_a: assert property ($past(current_on) &&
        alarm_code == CODE_OPDATA |-> motor_energise)
        else $error("energised alarm dropped current");

    dev_off_a: assert property (!alarm_active && cand == ALM_DEV_OFF
        |=> alarm_code == CODE_DEV_OFF && !motor_energise)
        else $error("current-off deviation alarm missing");

    // DC variant never shows AC codes
    dc_codes_a: assert property (!AC_VARIANT |->
        alarm_code != CODE_MAINOFF && alarm_code != CODE_SHORT &&
        alarm_code != CODE_CABLE)
        else $error("AC-only alarm on DC variant");

    gear_check_a: assert property (pwrup_r && !alarm_active &&
        cand == ALM_GEAR |=> alarm_code == CODE_GEAR && !desc_r.resettable)
        else $error("gear alarm not raised");

    mainoff_code_a: assert property (alarm_code == CODE_MAINOFF |->
        grp_lines == GRP_3 && blink_count == 4'h3 && desc_r.resettable)
        else $error("main-off alarm coding wrong");

    underv_code_a: assert property (alarm_code == CODE_UNDERV |->
        grp_lines == GRP_3 && blink_count == 4'h3 && desc_r.resettable)
        else $error("undervoltage alarm coding wrong");

    devoff_code_a: assert property (alarm_code == CODE_DEV_OFF |->
        grp_lines == GRP_4 && blink_count == 4'h4 && desc_r.resettable)
        else $error("current-off deviation coding wrong");

    cable_code_a: assert property (alarm_code == CODE_CABLE |->
        grp_lines == GRP_5 && blink_count == 4'h5 && !desc_r.resettable)
        else $error("cable alarm coding wrong");

    snsrun_code_a: assert property (alarm_code == CODE_SNS_RUN |->
        grp_lines == GRP_8 && blink_count == 4'h8 && !desc_r.resettable)
        else $error("running sensor coding wrong");

    snsinit_code_a: assert property (alarm_code == CODE_SNS_INIT |->
        grp_lines == GRP_8 && blink_count == 4'h8 && !desc_r.resettable)
        else $error("power-up sensor coding wrong");

    rotor_code_a: assert property (alarm_code == CODE_ROTOR |->
        grp_lines == GRP_8 && blink_count == 4'h8 && !desc_r.resettable)
        else $error("rotor turning coding wrong");

    mtype_code_a: assert property (alarm_code == CODE_MTYPE |->
        grp_lines == GRP_8 && blink_count == 4'h8 && !desc_r.resettable)
        else $error("motor type coding wrong");

    opdata_code_a: assert property (alarm_code == CODE_OPDATA |->
        grp_lines == GRP_7 && blink_count == 4'h7 && desc_r.resettable)
        else $error("operation data coding wrong");

    set_wins_a: assert property (alarm_active && desc_r.resettable &&
        clr_req && cand != ALM_NONE |=> alarm_active)
        else $error("present fault lost on clear");

    brake_follow_a: assert property (brake_release |->
        motor_energise && $past(brake_fitted))
        else $error("brake released without current");

    idle_energise_a: assert property (!alarm_active && $past(resetn)
        |-> motor_energise == $past(current_on))
        else $error("motor current not following request");

    blink_active_a: assert property (alarm_active ==
        (blink_count != 4'h0))
        else $error("blink count and alarm disagree");

    led_dark_a: assert property (!alarm_active |=> !alarm_led)
        else $error("LED lit without alarm");

    hard_latch_a: assert property (alarm_active && !desc_r.resettable
        |=> alarm_active && $stable(alarm_code))
        else $error("hard alarm not held");

    short_trig_a: assert property (!alarm_active && AC_VARIANT &&
        sense.short_det && !sense.supply_over |=> alarm_code == CODE_SHORT)
        else $error("short alarm not raised");

    cable_trig_a: assert property (!alarm_active && AC_VARIANT &&
        sense.cable_open && !sense.short_det && !sense.supply_over
        |=> alarm_code == CODE_CABLE)
        else $error("cable alarm not raised");

    dev_raise_a: assert property (!alarm_active && current_on &&
        sense.deviation_over |=> alarm_active)
        else $error("deviation alarm not raised");

    underv_raise_a: assert property (!alarm_active &&
        sense.main_undervolt |=> alarm_active)
        else $error("undervoltage alarm not raised");

endmodule : mdae_top

// ### tb/mdae_host.sv
// Host controller model: motor current and alarm clear requests
`timescale 1ns/1ps
module mdae_host (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic want_current,
    input  wire logic ignore_warn,
    input  wire logic clear_req,
    input  wire logic tool_req,
    input  wire logic off_warn,
    output logic      current_on,
    output logic      alarm_clear_input,
    output logic      tool_reset
);
    always_ff @(posedge clk) begin
        current_on <= resetn & want_current & (~off_warn | ignore_warn);
    end

    always_ff @(posedge clk) begin
        alarm_clear_input <= resetn & clear_req;
        tool_reset        <= resetn & tool_req & ~tool_reset;
    end
endmodule : mdae_host

// ### tb/mdae_top_test.sv
// Self-checking bench for the alarm encoder with a host model
`timescale 1ns/1ps
module mdae_top_test
    import mdae_pkg::*;
;
    localparam int unsigned TICK = 4;
    localparam logic [15:0] OKS  = 16'h6000;
    localparam logic [15:0] G    = 16'h03E8;
    logic        clk;
    logic        resetn;
    mdae_sense_t sense;
    logic [15:0] gear_resolution;
    logic [15:0] speed;
    logic        want, ignore, clr, tool, brake_fitted;
    logic        current_on, alarm_clear_input, tool_reset;
    logic        alarm_active, dc_active, motor_energise, brake_release;
    logic        alarm_group_bit2, alarm_group_bit1, alarm_group_bit0;
    logic        alarm_led;
    logic [7:0]  alarm_code;
    logic [3:0]  blink_count;
    int          n_errors = 0;
    int          compares = 0;

    mdae_host host (
        .clk(clk), .resetn(resetn), .want_current(want),
        .ignore_warn(ignore), .clear_req(clr), .tool_req(tool),
        .off_warn(sense.off_overflow_warn), .current_on(current_on),
        .alarm_clear_input(alarm_clear_input), .tool_reset(tool_reset)
    );
    mdae_top #(.TICK_CYC(TICK)) uut (
        .clk(clk), .resetn(resetn), .sense(sense),
        .gear_resolution(gear_resolution), .shaft_speed_rpm(speed),
        .alarm_clear_input(alarm_clear_input), .tool_reset(tool_reset),
        .current_on(current_on), .brake_fitted(brake_fitted),
        .alarm_active(alarm_active), .alarm_code(alarm_code),
        .alarm_group_bit2(alarm_group_bit2),
        .alarm_group_bit1(alarm_group_bit1),
        .alarm_group_bit0(alarm_group_bit0), .blink_count(blink_count),
        .motor_energise(motor_energise), .brake_release(brake_release),
        .alarm_led(alarm_led)
    );
    // DC-supplied variant on the same stimulus
    mdae_top #(.AC_VARIANT(1'b0), .TICK_CYC(TICK)) uut_dc (
        .clk(clk), .resetn(resetn), .sense(sense),
        .gear_resolution(gear_resolution), .shaft_speed_rpm(speed),
        .alarm_clear_input(alarm_clear_input), .tool_reset(tool_reset),
        .current_on(current_on), .brake_fitted(brake_fitted),
        .alarm_active(dc_active), .alarm_code(), .alarm_group_bit2(),
        .alarm_group_bit1(), .alarm_group_bit0(), .blink_count(),
        .motor_energise(), .brake_release(), .alarm_led()
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wrap_up();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [7:0] c, input logic [2:0] g,
                       input logic [3:0] b, input logic e);
        compares++;
        if (alarm_active !== (c != 8'h00) || alarm_code !== c ||
            {alarm_group_bit2, alarm_group_bit1, alarm_group_bit0} !== g ||
            blink_count !== b || motor_energise !== e ||
            brake_release !== (e & brake_fitted)) begin
            n_errors++;
            $display("[FAIL] %0t code %h exp %h energise %b exp %b",
                     $time, alarm_code, c, motor_energise, e);
        end
    endtask : chk

    task automatic dck(input logic v);
        compares++;
        if (dc_active !== v) begin
            n_errors++;
            $display("[FAIL] %0t dc variant alarm %b exp %b", $time,
                     dc_active, v);
        end
    endtask : dck

    task automatic waitact(input logic v);
        int i;
        for (i = 0; i < 12 && alarm_active !== v; i++) begin
            @(posedge clk);
            #1;
        end
        repeat (2) @(posedge clk);
        #1;
    endtask : waitact

    task automatic pwr(input logic [15:0] gear);
        @(posedge clk);
        resetn          <= 1'b0;
        sense           <= mdae_sense_t'(OKS);
        gear_resolution <= gear;
        speed           <= 16'h0;
        want            <= 1'b0;
        ignore          <= 1'b0;
        clr             <= 1'b0;
        tool            <= 1'b0;
        brake_fitted    <= ~brake_fitted;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        #1;
        chk(8'h00, 3'h0, 4'h0, 1'b0);
        repeat (2) @(posedge clk);
    endtask : pwr

    task automatic t_hard(input logic [15:0] m, input logic [15:0] gear,
                          input logic [15:0] spd, input logic [7:0] c,
                          input logic [2:0] g, input logic [3:0] b,
                          input logic aco);
        pwr(gear);
        want  <= 1'b1;
        speed <= spd;
        sense <= mdae_sense_t'(OKS | m);
        waitact(c != 8'h00);
        chk(c, g, b, c == 8'h00);
        dck((c != 8'h00) & ~aco);
        @(posedge clk);
        sense <= mdae_sense_t'(OKS);
        clr   <= 1'b1;
        tool  <= 1'b1;
        @(posedge clk);
        tool <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk(c, g, b, c == 8'h00);
    endtask : t_hard

    // Flags f: energised, set wins, clear by tool, AC only
    task automatic t_soft(input logic [15:0] m, input logic ig,
                          input logic [7:0] c, input logic [2:0] g,
                          input logic [3:0] b, input logic [3:0] f);
        pwr(G);
        want   <= 1'b1;
        ignore <= ig;
        sense  <= mdae_sense_t'(OKS ^ m);
        waitact(c != 8'h00);
        chk(c, g, b, f[3]);
        dck((c != 8'h00) & ~f[0]);
        if (c != 8'h00) begin
            @(posedge clk);
            clr <= 1'b1;
            repeat (4) @(posedge clk);
            #1;
            chk(f[2] ? c : 8'h00, f[2] ? g : 3'h0, f[2] ? b : 4'h0,
                f[2] ? f[3] : 1'b1);
            @(posedge clk);
            clr   <= 1'b0;
            sense <= mdae_sense_t'(OKS);
            repeat (3) @(posedge clk);
            clr  <= ~f[1];
            tool <= f[1];
            @(posedge clk);
            tool <= 1'b0;
            waitact(1'b0);
            chk(8'h00, 3'h0, 4'h0, 1'b1);
        end
    endtask : t_soft

    task automatic t_one();
        pwr(G);
        sense <= mdae_sense_t'(OKS | 16'h0800);
        waitact(1'b1);
        chk(CODE_UNDERV, GRP_3, 4'h3, 1'b0);
        @(posedge clk);
        sense <= mdae_sense_t'(OKS | 16'h8800);
        repeat (5) @(posedge clk);
        #1;
        chk(CODE_UNDERV, GRP_3, 4'h3, 1'b0);
        @(posedge clk);
        tool <= 1'b1;
        @(posedge clk);
        tool <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk(CODE_OVERVOLT, GRP_3, 4'h3, 1'b0);
    endtask : t_one

    task automatic t_led(input logic [15:0] m, input int n);
        int   k;
        int   rises;
        logic p;
        pwr(G);
        sense <= mdae_sense_t'(OKS | m);
        waitact(n != 0);
        p = alarm_led;
        rises = 0;
        for (k = 0; k < (2 * n + 4) * TICK; k++) begin
            @(posedge clk);
            #1;
            if (alarm_led === 1'b1 && p === 1'b0) rises++;
            p = alarm_led;
        end
        compares++;
        if (rises != n) begin
            n_errors++;
            $display("[FAIL] %0t led blinks %0d exp %0d", $time, rises, n);
        end
    endtask : t_led

    initial begin
        #100_000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        resetn          = 1'b0;
        sense           = mdae_sense_t'(OKS);
        gear_resolution = G;
        speed           = 16'h0;
        want            = 1'b0;
        ignore          = 1'b0;
        clr             = 1'b0;
        tool            = 1'b0;
        brake_fitted    = 1'b0;
        t_hard(16'h8000, G, 16'h0, CODE_OVERVOLT, GRP_3, 4'h3, 1'b0);
        t_hard(16'h0100, G, 16'h0, CODE_SHORT, GRP_5, 4'h5, 1'b1);
        t_hard(16'h0080, G, 16'h0, CODE_CABLE, GRP_5, 4'h5, 1'b1);
        t_hard(16'h0004, G, 16'h0, CODE_STORE, GRP_9, 4'h9, 1'b0);
        t_hard(16'h0008, G, 16'h0, CODE_MTYPE, GRP_8, 4'h8, 1'b0);
        t_hard(16'h0060, G, 16'h0, CODE_SNS_RUN, GRP_8, 4'h8, 1'b0);
        t_hard(16'h0050, G, 16'h0, CODE_SNS_INIT, GRP_8, 4'h8, 1'b0);
        t_hard(16'h0010, G, 16'hF, CODE_ROTOR, GRP_8, 4'h8, 1'b0);
        t_hard(16'h0010, G, 16'hE, 8'h00, 3'h0, 4'h0, 1'b0);
        t_hard(16'h0, 16'h0063, 16'h0, CODE_GEAR, GRP_7, 4'h7, 1'b0);
        t_hard(16'h0, 16'h0064, 16'h0, 8'h00, 3'h0, 4'h0, 1'b0);
        t_hard(16'h0, 16'h2710, 16'h0, 8'h00, 3'h0, 4'h0, 1'b0);
        t_hard(16'h0, 16'h2711, 16'h0, CODE_GEAR, GRP_7, 4'h7, 1'b0);
        t_soft(16'h5000, 1'b0, CODE_MAINOFF, GRP_3, 4'h3, 4'h5);
        t_soft(16'h0800, 1'b0, CODE_UNDERV, GRP_3, 4'h3, 4'h6);
        t_soft(16'h0400, 1'b0, CODE_DEV_ON, GRP_4, 4'h4, 4'h4);
        t_soft(16'h0200, 1'b1, CODE_DEV_OFF, GRP_4, 4'h4, 4'h2);
        t_soft(16'h0200, 1'b0, 8'h00, 3'h0, 4'h0, 4'h0);
        t_soft(16'h0003, 1'b0, CODE_OPDATA, GRP_7, 4'h7, 4'hC);
        t_one();
        t_led(16'h8000, 3);
        t_led(16'h0004, 9);
        t_led(16'h0000, 0);
        wrap_up();
    end
endmodule : mdae_top_test
